/* design/amc_defines.svh */
/*
  constants for the converter input mux configuration decoder.
  assumes inclusion by bare name from design files under design/.
*/
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH

// ********************************************************
// word layout
// ********************************************************
`define AMC_CFG_BITS      14
`define AMC_CNT_W         4
`define AMC_BW_BIT        6
`define AMC_CH_LSB        7
`define AMC_CH_MSB        9
`define AMC_INCC_LSB      10
`define AMC_INCC_MSB      12

// ********************************************************
// input configuration codes
// ********************************************************
`define AMC_INCC_SE_GND   3'h7
`define AMC_INCC_COM_BIP  3'h2
`define AMC_INCC_COM_UNI  3'h6
`define AMC_INCC_PAIR_BIP 2'h0
`define AMC_INCC_PAIR_UNI 2'h2

// ********************************************************
// reset values and common negative input code
// ********************************************************
`define AMC_RST_CH        3'h0
`define AMC_RST_NEG       4'h8
`define AMC_NEG_COM       4'h8

`endif

/* design/amc_pkg.sv */
/*
  types for the converter input mux configuration decoder.
  assumes amc_defines.svh is visible on the include path.
*/
`include "amc_defines.svh"

package amc_pkg;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    AMC_MODE_SE_GND,
    AMC_MODE_COM_BIP,
    AMC_MODE_COM_UNI,
    AMC_MODE_PAIR_BIP,
    AMC_MODE_PAIR_UNI
  } amc_mode_t;

  typedef struct packed {
    amc_mode_t   mode;
    logic [2:0]  positive_input;
    logic [3:0]  negative_input;
    logic        bipolar;
    logic        twos_complement;
    logic        filter_bandwidth;
  } amc_mux_t;

endpackage : amc_pkg

/* design/amc_decoder.sv */
/*
  configuration word capture and decode into mux settings and code format.
  assumes serial clock edges arrive as one-cycle pulses on sys_clk_i and a
  transfer frame level marks the transfer; negative_input 8 means common.
*/
`timescale 1ns/10ps
`default_nettype none

`include "amc_defines.svh"

module amc_decoder (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire logic            frame_i,
  input  wire logic            sck_rise_i,
  input  wire logic            sdi_i,
  input  wire logic            seq_run_i,
  output var  amc_pkg::amc_mux_t mux_o,
  output logic                 cfg_valid_o
);
  import amc_pkg::*;

  // ********************************************************
  // word capture state
  // ********************************************************
  logic [`AMC_CFG_BITS-1:0] shift_r;
  logic [`AMC_CNT_W-1:0]    bit_cnt_r;
  logic                     take_bit;
  logic                     last_bit;
  logic                     word_done_r;

  // ********************************************************
  // decoded fields
  // ********************************************************
  logic [2:0]               incc;
  logic [2:0]               chan;
  amc_mode_t                mode_nxt;
  logic                     bip_nxt;
  logic                     pair_mode;
  logic [2:0]               pos_nxt;
  logic [3:0]               neg_nxt;

  // ********************************************************
  // output state
  // ********************************************************
  amc_mode_t                mode_r;
  logic [2:0]               pos_r;
  logic [3:0]               neg_r;
  logic                     bip_r;
  logic                     fmt_r;
  logic                     bw_r;
  logic                     valid_r;

  // ********************************************************
  // bit qualification
  // ********************************************************
  // only first fourteen edges count
  assign take_bit = frame_i && sck_rise_i &&
                    (bit_cnt_r < `AMC_CNT_W'(`AMC_CFG_BITS));
  assign last_bit = (bit_cnt_r == `AMC_CNT_W'(`AMC_CFG_BITS - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shift_r <= '0;
    end else if (take_bit) begin
      shift_r <= {shift_r[`AMC_CFG_BITS-2:0], sdi_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bit_cnt_r <= '0;
    end else if (!frame_i) begin
      // an aborted transfer leaves the old settings in place
      bit_cnt_r <= '0;
    end else if (take_bit) begin
      bit_cnt_r <= bit_cnt_r + `AMC_CNT_W'(1);
    end
  end

  // one-cycle strobe after the last bit lands in shift_r
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      word_done_r <= 1'b0;
    end else begin
      word_done_r <= take_bit && last_bit;
    end
  end

  // ********************************************************
  // field split
  // ********************************************************
  assign incc = shift_r[`AMC_INCC_MSB:`AMC_INCC_LSB];
  assign chan = shift_r[`AMC_CH_MSB:`AMC_CH_LSB];

  // ********************************************************
  // input configuration decode
  // ********************************************************
  // decode is stateless per word
  always_comb begin
    mode_nxt = AMC_MODE_SE_GND;
    bip_nxt  = 1'b0;
    case (incc)
      `AMC_INCC_SE_GND: begin
        mode_nxt = AMC_MODE_SE_GND;
        bip_nxt  = 1'b0;
      end
      `AMC_INCC_COM_BIP: begin
        mode_nxt = AMC_MODE_COM_BIP;
        bip_nxt  = 1'b1;
      end
      `AMC_INCC_COM_UNI: begin
        mode_nxt = AMC_MODE_COM_UNI;
        bip_nxt  = 1'b0;
      end
      default: begin
        // code 011 falls to unipolar pairs; it has no mode of its own
        // bipolar pairs, low bit ignored
        if (incc[2:1] == `AMC_INCC_PAIR_BIP) begin
          mode_nxt = AMC_MODE_PAIR_BIP;
          bip_nxt  = 1'b1;
        end else begin
          mode_nxt = AMC_MODE_PAIR_UNI;
          bip_nxt  = 1'b0;
        end
      end
    endcase
  end

  assign pair_mode = (mode_nxt == AMC_MODE_PAIR_BIP) ||
                     (mode_nxt == AMC_MODE_PAIR_UNI);

  // ********************************************************
  // channel selection
  // ********************************************************
  // channel field picks positive
  always_comb begin
    pos_nxt = chan;
    if (pair_mode && seq_run_i) begin
      pos_nxt = {chan[2:1], 1'b0};
    end
  end

  always_comb begin
    neg_nxt = `AMC_NEG_COM;
    if (pair_mode) begin
      neg_nxt = {1'b0, pos_nxt ^ 3'h1};
    end
  end

  // ********************************************************
  // output registers
  // ********************************************************
  // hold until next full word
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_r <= AMC_MODE_SE_GND;
    end else if (word_done_r) begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pos_r <= `AMC_RST_CH;
    end else if (word_done_r) begin
      pos_r <= pos_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      neg_r <= `AMC_RST_NEG;
    end else if (word_done_r) begin
      neg_r <= neg_nxt;
    end
  end

  // range flag follows the decoded mode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bip_r <= 1'b0;
    end else if (word_done_r) begin
      bip_r <= bip_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fmt_r <= 1'b0;
    end else if (word_done_r) begin
      fmt_r <= bip_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bw_r <= 1'b0;
    end else if (word_done_r) begin
      bw_r <= shift_r[`AMC_BW_BIT];
    end
  end

  // sticky: once a word is in, settings are always meaningful
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
    end else if (word_done_r) begin
      valid_r <= 1'b1;
    end
  end

  // ********************************************************
  // port wiring
  // ********************************************************
  assign mux_o = '{mode:             mode_r,
                   positive_input:   pos_r,
                   negative_input:   neg_r,
                   bipolar:          bip_r,
                   twos_complement:  fmt_r,
                   filter_bandwidth: bw_r};
  assign cfg_valid_o = valid_r;

endmodule : amc_decoder

`default_nettype wire

/* verif/amc_checker.sv */
/* port checker for amc_decoder.
   assumes a bind onto every amc_decoder instance. */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// decoder port checks
// ****************************************
module amc_checker import amc_pkg::*; (
  input wire logic     sys_clk_i, rst_i, frame_i, sck_rise_i, sdi_i,
  input wire logic     seq_run_i,
  input wire amc_mux_t mux_o,
  input wire logic     cfg_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic pr = mux_o.mode inside {AMC_MODE_PAIR_BIP, AMC_MODE_PAIR_UNI};
  chk_fmt_range: assert property
    (mux_o.twos_complement == mux_o.bipolar) else $error("format wrong");
  chk_bip_mode: assert property (mux_o.bipolar == (mux_o.mode inside
    {AMC_MODE_COM_BIP, AMC_MODE_PAIR_BIP})) else $error("range wrong");
  chk_pair_neg: assert property (pr |-> mux_o.negative_input ==
    {1'b0, mux_o.positive_input ^ 3'h1}) else $error("partner wrong");
  chk_com_neg: assert property (mux_o.mode inside {AMC_MODE_COM_BIP,
    AMC_MODE_COM_UNI} |-> mux_o.negative_input == 4'h8) else $error("com");
  chk_seq_even: assert property ($changed(mux_o) && pr &&
    $past(seq_run_i) |-> !mux_o.positive_input[0]) else $error("odd pos");
  chk_idle_hold: assert property (!frame_i && !$past(frame_i) &&
    !$past(frame_i, 2) |-> $stable(mux_o)) else $error("changed idle");
  chk_valid_keep: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("valid dropped");
  chk_valid_rise: assert property ($rose(cfg_valid_o) |->
    $past(sck_rise_i, 2)) else $error("valid early");
endmodule : amc_checker
bind amc_decoder amc_checker chk (.sys_clk_i, .rst_i, .frame_i, .sck_rise_i,
  .sdi_i, .seq_run_i, .mux_o, .cfg_valid_o);
`default_nettype wire

/* verif/amc_host.sv */
/* host model that shifts configuration words in.
   assumes one sck_o pulse per cycle is acceptable. */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// serial writer
// ****************************************
module amc_host (
  input  wire logic clk_i,
  output logic      frame_o,
  output logic      sck_o,
  output logic      sdi_o
);
  initial frame_o = 1'b0;
  initial sck_o = 1'b0;
  initial sdi_o = 1'b0;
  // no conversions issued, no rate to lower
  // msb first, one bit per pulse
  task send(input logic [13:0] w, input int n);
    @(negedge clk_i) frame_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i) sck_o = 1'b1;
      sdi_o = (i < 14) ? w[13 - i] : ~sdi_o;
    end
    @(negedge clk_i) sck_o = 1'b0;
    frame_o = 1'b0;
    // released line must not show the last bit
    sdi_o = ~sdi_o;
  endtask : send
endmodule : amc_host
`default_nettype wire

/* verif/tb.sv */
/* self-checking bench for amc_decoder.
   assumes amc_host and the bound checker are compiled. */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb;
  import amc_pkg::*;
  logic      sys_clk_i = 1'b0, rst_i = 1'b1, seq_run_i = 1'b0, valid;
  wire logic frame, sck, sdi;
  amc_mux_t  mux;
  int        fail_count = 0, checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  amc_host host (.clk_i(sys_clk_i), .frame_o(frame), .sck_o(sck), .sdi_o(sdi));
  amc_decoder dut (.sys_clk_i, .rst_i, .frame_i(frame), .sck_rise_i(sck),
    .sdi_i(sdi), .seq_run_i, .mux_o(mux), .cfg_valid_o(valid));
  function automatic amc_mux_t ex(input logic [13:0] w, input logic s);
    amc_mux_t e;
    e = '0;
    e.filter_bandwidth = w[6];
    e.positive_input = w[9:7];
    e.negative_input = 4'h8;
    case (w[12:10])
      3'h7: e.mode = AMC_MODE_SE_GND;
      3'h2: e.mode = AMC_MODE_COM_BIP;
      3'h6: e.mode = AMC_MODE_COM_UNI;
      3'h0, 3'h1: e.mode = AMC_MODE_PAIR_BIP;
      default: e.mode = AMC_MODE_PAIR_UNI;
    endcase
    if (e.mode inside {AMC_MODE_PAIR_BIP, AMC_MODE_PAIR_UNI}) begin
      if (s) e.positive_input[0] = 1'b0;
      e.negative_input = {1'b0, e.positive_input ^ 3'h1};
    end
    e.bipolar = e.mode inside {AMC_MODE_COM_BIP, AMC_MODE_PAIR_BIP};
    e.twos_complement = e.bipolar;
    return e;
  endfunction : ex
  task cmp(input amc_mux_t e, input logic v);
    repeat (4) @(negedge sys_clk_i);
    checks++;
    if (mux !== e || valid !== v) begin
      fail_count++;
      $display("unexpected mux exp %h %b got %h %b", e, v, mux, valid);
    end
  endtask : cmp
  task t_reset;
    cmp(ex(14'h1C00, 1'b0), 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task t_modes;
    logic [13:0] w;
    for (int m = 0; m < 8; m++) begin
      w = {1'b0, m[2:0], 3'(7 - m), m[0], 6'h15};
      host.send(w, 14);
      cmp(ex(w, 1'b0), 1'b1);
    end
    $display("t_modes done");
  endtask : t_modes
  task t_seq;
    host.send(14'h0280, 14);
    cmp(ex(14'h0280, 1'b0), 1'b1);
    seq_run_i = 1'b1;
    host.send(14'h0280, 14);
    cmp(ex(14'h0280, 1'b1), 1'b1);
    seq_run_i = 1'b0;
    $display("t_seq done");
  endtask : t_seq
  task t_refuse;
    host.send(14'h3A40, 16);
    cmp(ex(14'h3A40, 1'b0), 1'b1);
    host.send(14'h0000, 10);
    cmp(ex(14'h3A40, 1'b0), 1'b1);
    host.send(14'h1F80, 14);
    cmp(ex(14'h1F80, 1'b0), 1'b1);
    $display("t_refuse done");
  endtask : t_refuse
  task print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_modes();
    t_seq();
    t_refuse();
    print_verdict();
  end
  // tests take well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
